// file: common/jrx_consts.svh
// Register offsets, reset values and timing counts of the lane receiver
`ifndef JRX_CONSTS_SVH
`define JRX_CONSTS_SVH
`define JRX_OFS_IF_PD      15'h0200
`define JRX_OFS_LANE_PD    15'h0201
`define JRX_OFS_STATUS     15'h0202
`define JRX_RST_IF_PD      8'h01
`define JRX_RST_LANE_PD    8'h00
`define JRX_IF_PD_BIT      0
`define JRX_CHAR_COMMA     8'hbc
`define JRX_CHAR_ILAS_R    8'h1c
`define JRX_FRAMES_PER_MF  32
`define JRX_ILAS_MF        4
`define JRX_RATE_MIN_MBPS  3000
`define JRX_RATE_MAX_MBPS  15000
`define JRX_CONV_COUNT     2
`endif

// file: common/jrx_pkg.sv
// Shared types of the lane receiver
package jrx_pkg;
  typedef enum logic [2:0] {
    JRX_MODE0 = 3'h0,
    JRX_MODE3 = 3'h3,
    JRX_MODE5 = 3'h5
  } jrx_mode_t;

  typedef enum logic [3:0] {
    JRX_SYNC      = 4'h1,
    JRX_WAIT_LMFC = 4'h2,
    JRX_ILAS      = 4'h4,
    JRX_DATA      = 4'h8
  } jrx_lstate_t;

  // One decoded symbol from a lane
  typedef struct packed {
    logic       k;
    logic       err;
    logic [7:0] octet;
  } jrx_sym_t;

  // One frame's worth of samples, 16-bit data in modes 0 and 3, 12-bit data left justified in mode 5
  typedef struct packed {
    logic [15:0] conv1;
    logic [15:0] conv0;
  } jrx_samp_t;

  typedef struct packed {
    logic [3:0]  chan_interp;
    logic [3:0]  main_interp;
    logic [15:0] dac_rate_mhz;
    jrx_mode_t   mode;
    logic        dual_link;
    logic        descramble_en;
  } jrx_cfg_t;
endpackage

// file: core/jrx_deframer.sv
// Lane receiver: lane sync, alignment, descrambling and deframing
// What this block does
// - Eight lanes, one or two links, shared SYSREF
// - Lane octets descrambled then deframed into samples
// - Descrambling is a selectable option
// - Mode 0: one lane, c0 hi/lo, c1 hi/lo
// - Mode 3: lane per converter, high octet first
// - Mode 5: two 12-bit samples in six nibbles over three octets
// - Thirty-two frames per multiframe, one sample, HD
// - Sample rate uses channel times main interpolation
// - Lane rate must lie in 3 to 15 Gbps
// - Complex data only when total interpolation exceeds one
// - One sync request output per link
// - Each lane gathers forty-bit demux words
// - Interface powered down until bit 0 cleared
// - Per-lane power-down bit at lane index
// - Termination calibration needs no register writes
// - Four commas on all powered-up lanes of the link, release at LMFC
// - Elastic buffers release all lanes together
`timescale 1ns/10ps
`include "jrx_consts.svh"

module jrx_deframer #(
  parameter int NUM_LANES = 8,
  parameter int EB_DEPTH  = 8
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Lanes and system reference
  input  wire jrx_pkg::jrx_sym_t     serial_lane_in [NUM_LANES],
  input  wire logic                  sysref_in,
  // Static configuration
  input  wire jrx_pkg::jrx_cfg_t     cfg,
  // Register port
  input  wire logic [14:0]           reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Synchronisation requests, low requests resync
  output logic                       link0_sync_request_out_b,
  output logic                       link1_sync_request_out_b,
  // Sample streams, one per link
  output logic                       sample_valid [2],
  input  wire logic                  sample_ready [2],
  output jrx_pkg::jrx_samp_t         sample_out [2],
  // Status
  output logic                       lane_rate_ok,
  output logic                       complex_data
);
  localparam int AW = $clog2(EB_DEPTH);

  initial begin
    if (NUM_LANES != 8 || EB_DEPTH < 2 || (1 << AW) != EB_DEPTH) begin
      $error("jrx_deframer: unsupported lane count or buffer depth");
    end
  end

  typedef struct packed {
    jrx_pkg::jrx_sym_t [3:0]          demux;
    logic                             started;
    logic [14:0]                      scr;
    jrx_pkg::jrx_sym_t [EB_DEPTH-1:0] mem;
    logic [AW:0]                      wp;
    logic [AW:0]                      rp;
  } jrx_lane_t;

  typedef struct packed {
    jrx_pkg::jrx_lstate_t         st;
    logic                         sync_b;
    logic [7:0]                   lmfc;
    logic [9:0]                   skip;
    logic [1:0]                   idx;
    logic [31:0]                  acc0;
    logic [15:0]                  acc1;
    jrx_pkg::jrx_samp_t [1:0]     buff;
    logic [1:0]                   fill;
  } jrx_link_t;

  typedef struct packed {
    logic [7:0]                   if_pd;
    logic [7:0]                   lane_pd;
    logic [7:0]                   rdata;
    logic                         sysref_d;
    logic                         rate_ok;
    logic                         cplx;
    jrx_lane_t [NUM_LANES-1:0]    ln;
    jrx_link_t [1:0]              lk;
  } jrx_state_t;

  jrx_state_t r_r;
  jrx_state_t r_nxt;

  function automatic logic is_comma(jrx_pkg::jrx_sym_t s);
    return s.k && !s.err && s.octet == `JRX_CHAR_COMMA;
  endfunction

  function automatic logic in_link(int i, int l, logic dual);
    return dual ? ((i / 4) == l) : (l == 0);
  endfunction

  // Self-synchronous 1 + x^14 + x^15, MSB first
  function automatic logic [22:0] descr(logic [7:0] d, logic [14:0] s);
    logic [14:0] t;
    logic [7:0]  o;
    t = s;
    o = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      o[b] = d[b] ^ t[13] ^ t[14];
      t    = {t[13:0], d[b]};
    end
    return {t, o};
  endfunction

  logic [31:0] num;
  logic [31:0] den;
  logic [1:0]  lanes_l;
  logic [4:0]  np;
  logic [7:0]  mf_len;
  logic [1:0]  last_idx;

  always_comb begin
    // Lane rate = dac * M * NP * 10 / (8 * L * total interpolation)
    lanes_l  = (cfg.mode == jrx_pkg::JRX_MODE3) ? 2'h2 : 2'h1;
    np       = (cfg.mode == jrx_pkg::JRX_MODE5) ? 5'hc : 5'h10;
    last_idx = (cfg.mode == jrx_pkg::JRX_MODE0) ? 2'h3 : (cfg.mode == jrx_pkg::JRX_MODE3) ? 2'h1 : 2'h2;
    mf_len   = 8'(`JRX_FRAMES_PER_MF * (int'(last_idx) + 1));
    num      = 32'(cfg.dac_rate_mhz) * 32'(`JRX_CONV_COUNT) * 32'(np) * 32'h0000000a;
    den      = 32'h8 * 32'(lanes_l) * 32'(cfg.chan_interp) * 32'(cfg.main_interp);
  end

  logic [NUM_LANES-1:0] active;
  logic [NUM_LANES-1:0] cgs_ok;
  logic [NUM_LANES-1:0] ready;
  logic [1:0]           rd;

  always_comb begin
    r_nxt = r_r;
    r_nxt.sysref_d = sysref_in;
    r_nxt.rate_ok  = den != 32'h0 && num >= 32'(`JRX_RATE_MIN_MBPS) * den
                     && num <= 32'(`JRX_RATE_MAX_MBPS) * den;
    r_nxt.cplx     = (cfg.chan_interp * cfg.main_interp) > 8'h01;
    // Register port, termination calibration runs without any write here
    if (reg_wr && reg_addr == `JRX_OFS_IF_PD) begin
      r_nxt.if_pd = reg_wdata;
    end
    if (reg_wr && reg_addr == `JRX_OFS_LANE_PD) begin
      r_nxt.lane_pd = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        `JRX_OFS_IF_PD:   r_nxt.rdata = r_r.if_pd;
        `JRX_OFS_LANE_PD: r_nxt.rdata = r_r.lane_pd;
        `JRX_OFS_STATUS:  r_nxt.rdata = {2'h0, r_r.lk[1].st == jrx_pkg::JRX_DATA, r_r.lk[1].sync_b,
                                         r_r.lk[0].st == jrx_pkg::JRX_DATA, r_r.lk[0].sync_b,
                                         r_r.cplx, r_r.rate_ok};
        default:          r_nxt.rdata = 8'h00;
      endcase
    end

    for (int i = 0; i < NUM_LANES; i++) begin
      active[i] = !r_r.if_pd[`JRX_IF_PD_BIT] && !r_r.lane_pd[i];
      cgs_ok[i] = &{is_comma(r_r.ln[i].demux[0]), is_comma(r_r.ln[i].demux[1]),
                    is_comma(r_r.ln[i].demux[2]), is_comma(r_r.ln[i].demux[3])};
      ready[i]  = r_r.ln[i].started && r_r.ln[i].wp != r_r.ln[i].rp;
    end

    for (int l = 0; l < 2; l++) begin
      logic       all_cgs;
      logic       lost;
      logic       any;
      logic       all_rdy;
      logic       pop;
      logic [7:0] o0;
      logic [7:0] o1;
      logic [22:0] d;
      jrx_pkg::jrx_samp_t smp;
      all_cgs = 1'b1;
      lost    = 1'b0;
      any     = 1'b0;
      all_rdy = 1'b1;
      o0      = 8'h00;
      o1      = 8'h00;
      d       = 23'h0;
      smp     = '0;
      for (int i = 0; i < NUM_LANES; i++) begin
        if (in_link(i, l, cfg.dual_link) && active[i]) begin
          any     = 1'b1;
          all_cgs = all_cgs && cgs_ok[i];
          lost    = lost || serial_lane_in[i].err;
          all_rdy = all_rdy && ready[i];
        end
      end
      // Multiframe clock, realigned on a SYSREF rising edge
      if (sysref_in && !r_r.sysref_d) begin
        r_nxt.lk[l].lmfc = 8'h00;
      end else begin
        r_nxt.lk[l].lmfc = (r_r.lk[l].lmfc >= mf_len - 8'h01) ? 8'h00 : r_r.lk[l].lmfc + 8'h01;
      end
      rd[l] = (r_r.lk[l].st == jrx_pkg::JRX_ILAS || r_r.lk[l].st == jrx_pkg::JRX_DATA)
              && any && all_rdy && !r_r.lk[l].fill[1];
      pop   = r_r.lk[l].fill[0] && sample_ready[l];
      if (pop) begin
        r_nxt.lk[l].buff[0] = r_r.lk[l].buff[1];
        r_nxt.lk[l].fill    = {1'b0, r_r.lk[l].fill[1]};
      end
      case (r_r.lk[l].st)
        jrx_pkg::JRX_SYNC: begin
          r_nxt.lk[l].sync_b = 1'b0;
          if (any && all_cgs && r_r.rate_ok && !lost) begin
            r_nxt.lk[l].st = jrx_pkg::JRX_WAIT_LMFC;
          end
        end
        jrx_pkg::JRX_WAIT_LMFC: begin
          if (r_r.lk[l].lmfc == 8'h00) begin
            r_nxt.lk[l].st     = jrx_pkg::JRX_ILAS;
            r_nxt.lk[l].sync_b = 1'b1;
            r_nxt.lk[l].skip   = 10'h000;
          end
        end
        jrx_pkg::JRX_ILAS: begin
          if (rd[l]) begin
            r_nxt.lk[l].skip = r_r.lk[l].skip + 10'h001;
            if (r_r.lk[l].skip == 10'(`JRX_ILAS_MF * int'(mf_len)) - 10'h001) begin
              r_nxt.lk[l].st  = jrx_pkg::JRX_DATA;
              r_nxt.lk[l].idx = 2'h0;
            end
          end
        end
        jrx_pkg::JRX_DATA: begin
          if (rd[l]) begin
            for (int j = 0; j < 2; j++) begin
              int p;
              p = l * 4 + j;
              d = descr(r_r.ln[p].mem[r_r.ln[p].rp[AW-1:0]].octet, r_r.ln[p].scr);
              r_nxt.ln[p].scr = d[22:8];
              if (j == 0) begin
                o0 = cfg.descramble_en ? d[7:0] : r_r.ln[p].mem[r_r.ln[p].rp[AW-1:0]].octet;
              end else begin
                o1 = cfg.descramble_en ? d[7:0] : r_r.ln[p].mem[r_r.ln[p].rp[AW-1:0]].octet;
              end
            end
            r_nxt.lk[l].acc0 = {r_r.lk[l].acc0[23:0], o0};
            r_nxt.lk[l].acc1 = {r_r.lk[l].acc1[7:0], o1};
            r_nxt.lk[l].idx  = r_r.lk[l].idx + 2'h1;
            if (r_r.lk[l].idx == last_idx) begin
              r_nxt.lk[l].idx = 2'h0;
              case (cfg.mode)
                jrx_pkg::JRX_MODE0: smp = {r_nxt.lk[l].acc0[15:0], r_nxt.lk[l].acc0[31:16]};
                jrx_pkg::JRX_MODE3: smp = {r_nxt.lk[l].acc1, r_nxt.lk[l].acc0[15:0]};
                jrx_pkg::JRX_MODE5: smp = {r_nxt.lk[l].acc0[11:0], 4'h0,
                                           r_nxt.lk[l].acc0[23:12], 4'h0};
                default:            smp = '0;
              endcase
              if (r_nxt.lk[l].fill[0]) begin
                r_nxt.lk[l].buff[1] = smp;
                r_nxt.lk[l].fill[1] = 1'b1;
              end else begin
                r_nxt.lk[l].buff[0] = smp;
                r_nxt.lk[l].fill[0] = 1'b1;
              end
            end
          end
        end
        default: r_nxt.lk[l].st = jrx_pkg::JRX_SYNC;
      endcase
      // Any lost lane or unusable setup drops the whole link
      if (lost || !any || !r_r.rate_ok || (l == 1 && !cfg.dual_link)) begin
        r_nxt.lk[l].st     = jrx_pkg::JRX_SYNC;
        r_nxt.lk[l].sync_b = 1'b0;
      end
    end

    for (int i = 0; i < NUM_LANES; i++) begin
      int l;
      l = (cfg.dual_link && i >= 4) ? 1 : 0;
      r_nxt.ln[i].demux = {r_r.ln[i].demux[2:0], serial_lane_in[i]};
      if (rd[l] && active[i]) begin
        r_nxt.ln[i].rp = r_r.ln[i].rp + 1'b1;
      end
      if (r_nxt.lk[l].st == jrx_pkg::JRX_SYNC || r_nxt.lk[l].st == jrx_pkg::JRX_WAIT_LMFC || !active[i]) begin
        r_nxt.ln[i].started = 1'b0;
        r_nxt.ln[i].wp      = '0;
        r_nxt.ln[i].rp      = '0;
      end else if (r_r.ln[i].wp[AW-1:0] != r_r.ln[i].rp[AW-1:0] || r_r.ln[i].wp[AW] == r_r.ln[i].rp[AW]) begin
        // Early lanes park here from their /R/ until the latest arrives
        if (r_r.ln[i].started || (serial_lane_in[i].k
            && serial_lane_in[i].octet == `JRX_CHAR_ILAS_R)) begin
          r_nxt.ln[i].started                    = 1'b1;
          r_nxt.ln[i].mem[r_r.ln[i].wp[AW-1:0]] = serial_lane_in[i];
          r_nxt.ln[i].wp                         = r_r.ln[i].wp + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_r         <= '0;
      r_r.if_pd   <= `JRX_RST_IF_PD;
      r_r.lane_pd <= `JRX_RST_LANE_PD;
      r_r.lk[0].st <= jrx_pkg::JRX_SYNC;
      r_r.lk[1].st <= jrx_pkg::JRX_SYNC;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign reg_rdata                = r_r.rdata;
  assign link0_sync_request_out_b = r_r.lk[0].sync_b;
  assign link1_sync_request_out_b = r_r.lk[1].sync_b;
  assign lane_rate_ok             = r_r.rate_ok;
  assign complex_data             = r_r.cplx;
  assign sample_valid[0]          = r_r.lk[0].fill[0];
  assign sample_valid[1]          = r_r.lk[1].fill[0];
  assign sample_out[0]            = r_r.lk[0].buff[0];
  assign sample_out[1]            = r_r.lk[1].buff[0];
endmodule

// file: bench/jrx_deframer_properties.sv
// Concurrent checks on the lane receiver ports
`timescale 1ns/10ps
module jrx_deframer_properties #(
  parameter int NUM_LANES = 8
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_b,
  // Lanes and configuration
  input wire jrx_pkg::jrx_sym_t  serial_lane_in [NUM_LANES],
  input wire jrx_pkg::jrx_cfg_t  cfg,
  // Register port
  input wire logic [14:0]        reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  // Link and samples
  input wire logic               link0_sync_request_out_b,
  input wire logic               link1_sync_request_out_b,
  input wire logic               sample_valid [2],
  input wire logic               sample_ready [2],
  input wire jrx_pkg::jrx_samp_t sample_out [2],
  input wire logic               lane_rate_ok,
  input wire logic               complex_data
);
  logic [7:0] pd0_r;
  logic [7:0] pd1_r;
  logic [7:0] err_act;
  logic       s0;
  logic       c0;
  assign s0 = link0_sync_request_out_b;
  assign c0 = serial_lane_in[0] == 10'h2bc;
  for (genvar i = 0; i < 8; i++) begin : g_err
    assign err_act[i] = serial_lane_in[i].err && !pd1_r[i] && !pd0_r[0];
  end
  // Shadow of the power-down registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd0_r <= 8'h01;
      pd1_r <= 8'h00;
    end else if (reg_wr && reg_addr == 15'h0200) begin
      pd0_r <= reg_wdata;
    end else if (reg_wr && reg_addr == 15'h0201) begin
      pd1_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rate; !lane_rate_ok |=> !s0; endproperty
  property p_err; s0 && |err_act |=> !s0; endproperty
  property p_ifpd; pd0_r[0] |=> !s0; endproperty
  property p_lk1; !cfg.dual_link |-> !link1_sync_request_out_b; endproperty
  property p_comma; $rose(s0) && !pd1_r[0] |-> $past(c0, 1) && $past(c0, 2) && $past(c0, 3) && $past(c0, 4); endproperty
  property p_hold; sample_valid[0] && !sample_ready[0] |=> sample_valid[0] && $stable(sample_out[0]); endproperty
  property p_pdrd;
    reg_rd && reg_addr[14:1] == 14'h0100 |=> reg_rdata == ($past(reg_addr[0]) ? $past(pd1_r) : $past(pd0_r));
  endproperty
  property p_stat;
    reg_rd && reg_addr == 15'h0202 |=> reg_rdata[2:0] == {$past(s0), $past(complex_data), $past(lane_rate_ok)};
  endproperty
  property p_cplx; 1'b1 |=> complex_data == (cfg.chan_interp * cfg.main_interp > 8'h01); endproperty
  a_rate: assert property (p_rate) else $error("sync released at bad lane rate");
  a_err: assert property (p_err) else $error("sync kept after lane error");
  a_ifpd: assert property (p_ifpd) else $error("sync released while powered down");
  a_lk1: assert property (p_lk1) else $error("link1 released in single link");
  a_comma: assert property (p_comma) else $error("sync released without four commas");
  a_hold: assert property (p_hold) else $error("sample lost under stall");
  a_pdrd: assert property (p_pdrd) else $error("power-down readback wrong");
  a_stat: assert property (p_stat) else $error("status readback wrong");
  a_cplx: assert property (p_cplx) else $error("complex flag wrong");
  cover property ($rose(s0));
  cover property (sample_valid[0] && sample_ready[0]);
  cover property (sample_valid[0] && !sample_ready[0]);
endmodule

// file: bench/jrx_tx_model.sv
// Transmitter model driving the two link 0 lanes
`timescale 1ns/10ps
module jrx_tx_model (
  // Clock and control
  input  wire logic               clk,
  input  wire logic               sync_b,
  input  wire logic               bad,
  input  wire jrx_pkg::jrx_mode_t mode,
  // Lane symbols
  output jrx_pkg::jrx_sym_t       ln [2]
);
  int          n = 0;
  int          f;
  int          d;
  logic [7:0]  fr;
  logic [31:0] v [2];
  always @(posedge clk) begin
    f = (mode == jrx_pkg::JRX_MODE0) ? 4 : (mode == jrx_pkg::JRX_MODE3) ? 2 : 3;
    d = n - 128 * f;
    fr = 8'(d / f);
    v[0] = (f == 4) ? {8'h0a, fr, 8'h05, fr} : (f == 2) ? {16'h0000, 8'h0a, fr} : {8'h00, 4'ha, fr, 4'h5, fr};
    v[1] = {16'h0000, 8'h05, fr};
    for (int i = 0; i < 2; i++) begin
      if (!sync_b) ln[i] <= 10'h2bc;
      else if (n == 0) ln[i] <= 10'h21c;
      else if (d < 0) ln[i] <= {2'h0, 8'(n)};
      else ln[i] <= {1'b0, bad, 8'(v[i] >> (8 * (f - 1 - d % f)))};
    end
    n = sync_b ? n + 1 : 0;
  end
endmodule

// file: bench/tb.sv
// Self-checking bench for the lane receiver
`timescale 1ns/10ps
module tb;
  typedef struct {
    jrx_pkg::jrx_mode_t m;
    logic [7:0]         ci_mi;
    logic [7:0]         pd;
    logic               ok;
    logic               cx;
  } jrx_row_t;
  logic               clk;
  logic               rst_b = 1'b0;
  logic               bad = 1'b0;
  jrx_pkg::jrx_sym_t  lin [8];
  jrx_pkg::jrx_sym_t  tx [2];
  jrx_pkg::jrx_cfg_t  cfg = '0;
  logic [14:0]        reg_addr = '0;
  logic [7:0]         reg_wdata = '0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [7:0]         reg_rdata;
  logic               s0;
  logic               s1;
  logic               sysref = 1'b0;
  logic               sample_valid [2];
  logic               sample_ready [2] = '{1'b0, 1'b1};
  jrx_pkg::jrx_samp_t sample_out [2];
  logic               lane_rate_ok;
  logic               complex_data;
  int                 cycles = 0;
  int                 n_errors = 0;
  int                 checks = 0;
  int                 t;
  jrx_row_t           rows [5];
  assign lin[0] = tx[0];
  assign lin[1] = tx[1];
  // Unused lanes carry errors and a changing pattern
  for (genvar i = 2; i < 8; i++) begin : g_junk
    assign lin[i] = {2'h1, 8'(cycles)};
  end
  jrx_tx_model tx_u (.clk(clk), .sync_b(s0), .bad(bad), .mode(cfg.mode), .ln(tx));
  jrx_deframer dut_u (
    .clk(clk), .rst_b(rst_b), .serial_lane_in(lin), .sysref_in(sysref), .cfg(cfg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link0_sync_request_out_b(s0), .link1_sync_request_out_b(s1), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_out(sample_out), .lane_rate_ok(lane_rate_ok),
    .complex_data(complex_data));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic wait_sync;
    t = 0;
    while (s0 !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rows[0] = '{jrx_pkg::JRX_MODE3, 8'h68, 8'hfc, 1'b0, 1'b1};
    rows[1] = '{jrx_pkg::JRX_MODE0, 8'h11, 8'hfe, 1'b0, 1'b0};
    rows[2] = '{jrx_pkg::JRX_MODE0, 8'h28, 8'hfe, 1'b1, 1'b1};
    rows[3] = '{jrx_pkg::JRX_MODE3, 8'h58, 8'hfc, 1'b1, 1'b1};
    rows[4] = '{jrx_pkg::JRX_MODE5, 8'h26, 8'hfe, 1'b1, 1'b1};
    foreach (rows[r]) begin
      rst_b <= 1'b0;
      cfg <= {rows[r].ci_mi, 16'h1770, rows[r].m, 2'h0};
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rd(15'h0200, 8'h01);
      rd(15'h0201, 8'h00);
      chk("lane_rate_ok", lane_rate_ok, rows[r].ok);
      chk("complex_data", complex_data, rows[r].cx);
      wr(15'h0201, rows[r].pd);
      wr(15'h0200, 8'h00);
      sysref <= 1'b1;
      @(posedge clk);
      sysref <= 1'b0;
      wait_sync();
      chk("sync1", s1, 1'b0);
      chk("valid1", sample_valid[1], 1'b0);
      chk("sync0", s0, rows[r].ok);
      for (int k = 0; k < 4 && rows[r].ok; k++) begin
        t = 0;
        do begin
          @(negedge clk);
          t++;
        end while (sample_valid[0] !== 1'b1 && t < 3000);
        chk("conv0", sample_out[0].conv0, (rows[r].m == jrx_pkg::JRX_MODE5) ? {4'ha, 8'(k), 4'h0} : {8'h0a, 8'(k)});
        chk("conv1", sample_out[0].conv1, (rows[r].m == jrx_pkg::JRX_MODE5) ? {4'h5, 8'(k), 4'h0} : {8'h05, 8'(k)});
        @(posedge clk);
        sample_ready[0] <= 1'b1;
        @(posedge clk);
        sample_ready[0] <= 1'b0;
      end
    end
    bad <= 1'b1;
    @(posedge clk);
    bad <= 1'b0;
    repeat (3) @(negedge clk);
    chk("sync0", s0, 1'b0);
    wait_sync();
    wr(15'h0202, 8'hff);
    rd(15'h0202, 8'h07);
    rd(15'h0300, 8'h00);
    wr(15'h0200, 8'h01);
    repeat (3) @(negedge clk);
    chk("sync0", s0, 1'b0);
    stop_test();
  end
endmodule
bind jrx_deframer jrx_deframer_properties #(.NUM_LANES(NUM_LANES)) chk_u (
  .clk, .rst_b, .serial_lane_in, .cfg, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .link0_sync_request_out_b, .link1_sync_request_out_b, .sample_valid, .sample_ready, .sample_out,
  .lane_rate_ok, .complex_data);
